// [logic/ifel_pkg.sv]
// constants shared by the interrupt flag and enable logic
package ifel_pkg;
    // register byte offsets on the apb slave
    localparam logic [11:0] OFS_INTERRUPT_CONTROL = 12'h000;
    localparam logic [11:0] OFS_OPTION            = 12'h004;
    localparam logic [11:0] OFS_PERIPH_FLAGS_A    = 12'h008;
    localparam logic [11:0] OFS_PERIPH_FLAGS_B    = 12'h00c;
    localparam logic [11:0] OFS_PERIPH_ENABLES_A  = 12'h010;
    localparam logic [11:0] OFS_PERIPH_ENABLES_B  = 12'h014;
    localparam logic [11:0] OFS_CORE_STATUS       = 12'h018;

    // interrupt_control field positions
    localparam int BIT_GLOBAL_IRQ_ENABLE      = 7;
    localparam int BIT_PERIPH_ENABLE          = 6;
    localparam int BIT_TIMER0_ROLLOVER_ENABLE = 5;
    localparam int BIT_EXT_PIN_ENABLE         = 4;
    localparam int BIT_PORT_CHANGE_ENABLE     = 3;
    localparam int BIT_TIMER0_ROLLOVER_FLAG   = 2;
    localparam int BIT_EXT_PIN_FLAG           = 1;
    localparam int BIT_PORT_CHANGE_FLAG       = 0;

    // option register field
    localparam int BIT_EXT_EDGE_SELECT = 6;

    // core_status field positions
    localparam int BIT_STAT_SLEEPING = 0;
    localparam int BIT_STAT_REQUEST  = 1;
    localparam int BIT_STAT_PENDING  = 2;

    // reset values
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_OPTION            = 8'hff;
    localparam logic [7:0] RST_PERIPH            = 8'h00;

    // program counter
    localparam int          PC_W       = 13;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] PC_STEP    = 13'h0001;

    // timer 0 rollover
    localparam logic [7:0] TMR_TOP    = 8'hff;
    localparam logic [7:0] TMR_BOTTOM = 8'h00;

    // bus
    localparam int         DATA_W   = 32;
    localparam int         REG_W    = 8;
    localparam int         SOURCE_N = 8;
    localparam int         PORT_HI_W = 4;
    localparam logic [23:0] READ_PAD = 24'h000000;
endpackage

// [logic/ifel_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ifel_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // asynchronous input and synchronised output
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    // stage1 feeds only the second flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule

// [logic/ifel_edge.sv]
// selectable edge detector on a synchronised level
`timescale 1ns/1ps
module ifel_edge (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level and edge choice, high selects rising
    input  wire logic level,
    input  wire logic rising_sel,
    // one-cycle edge pulse
    output logic      edge_seen
);
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    // changing the select while the pin is stable does not fire
    always_comb begin
        if (rising_sel) begin
            edge_seen = level & ~prev;
        end else begin
            edge_seen = ~level & prev;
        end
    end
endmodule

// [logic/ifel_top.sv]
// interrupt flag and enable logic with apb registers and wake control
// Operation
// - nineteen sources (three control, sixteen peripheral), each with its own flag and enable bit
// - flags set on their event regardless of any enable
// - global enable at bit 7 passes unmasked sources, blocks all when clear
// - global enable and flagged enabled source vector the core at once
// - every reset clears the global enable
// - acceptance clears global enable, pushes return, loads 0004h
// - return from interrupt sets the global enable again
// - external event to vector takes three or four cycles
// - peripheral flags and enables in two registers each, gated by one bit
// - external pin edge chosen by option bit 6, rising when set
// - external edge sets bit 1, masked by enable bit 4
// - external edge wakes only if its enable was set
// - timer 0 rollover ffh to 00h sets bit 2, masked by bit 5
// - upper port pin change sets bit 0, enable placed at bit 3
// - wake continues at pc plus one, or vector when global enabled
// - a wake leaves the causing flag set
// - enabled source wakes whatever the global enable state
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ifel_top (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // pins
    input  wire logic                 external_irq_pin,
    input  wire logic [3:0]           second_io_port_hi,
    // same-clock event sources
    input  wire logic [7:0]           timer_zero_count,
    input  wire logic [7:0]           periph_events_a,
    input  wire logic [7:0]           periph_events_b,
    // core sequencer
    input  wire logic                 return_from_irq_instr,
    input  wire logic                 sleep_instr,
    input  wire logic [12:0]          core_pc,
    output logic                      irq_request,
    output logic                      stack_push,
    output logic                      pc_load,
    output logic      [12:0]          next_pc,
    output logic                      sleeping
);
    logic [7:0]  interrupt_control;
    logic [7:0]  option_reg;
    logic [7:0]  periph_flags_a;
    logic [7:0]  periph_flags_b;
    logic [7:0]  periph_enables_a;
    logic [7:0]  periph_enables_b;
    logic [7:0]  tmr_prev;
    logic [3:0]  port_sync;
    logic [3:0]  port_prev;
    logic        ext_sync;
    logic        ext_edge;
    logic        tmr_roll;
    logic        port_change;
    logic        pending;
    logic        accept;
    logic        wake;
    logic        enter_sleep;
    logic        wr_access;
    logic        setup;
    logic        global_irq_enable;
    logic [3:0]  ctl_enables;
    logic [2:0]  ctl_flags;
    logic [7:0]  next_ctl;
    logic [7:0]  wbyte;
    logic [7:0]  next_rdata;
    logic        next_err;

    // flag update: hardware set wins over a software write
    function automatic logic [7:0] sticky(input logic [7:0] old,
                                          input logic [7:0] set,
                                          input logic       wr,
                                          input logic [7:0] wdata);
        logic [7:0] base;
        base = wr ? wdata : old;
        return base | set;
    endfunction

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // separate flops keep a single writer for each bit group
    assign interrupt_control = {global_irq_enable, ctl_enables, ctl_flags};
    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pready & pwrite;
    assign wbyte     = pwdata[ifel_pkg::REG_W-1:0];

    // pins pass two flops before any logic looks at them
    ifel_sync #(.W(1)) u_ext_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (external_irq_pin),
        .q       (ext_sync)
    );

    ifel_sync #(.W(ifel_pkg::PORT_HI_W)) u_port_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (second_io_port_hi),
        .q       (port_sync)
    );

    ifel_edge u_ext_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .level      (ext_sync),
        .rising_sel (option_reg[ifel_pkg::BIT_EXT_EDGE_SELECT]),
        .edge_seen  (ext_edge)
    );

    // event history for rollover and port change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_prev  <= ifel_pkg::TMR_BOTTOM;
            port_prev <= '0;
        end else begin
            tmr_prev  <= timer_zero_count;
            port_prev <= port_sync;
        end
    end

    assign tmr_roll = (tmr_prev == ifel_pkg::TMR_TOP) &&
                      (timer_zero_count == ifel_pkg::TMR_BOTTOM);
    assign port_change = |(port_sync ^ port_prev);

    // nineteen sources, three control and sixteen peripheral, each flag and enable paired
    always_comb begin
        pending =
            (interrupt_control[ifel_pkg::BIT_TIMER0_ROLLOVER_FLAG] &
             interrupt_control[ifel_pkg::BIT_TIMER0_ROLLOVER_ENABLE]) |
            (interrupt_control[ifel_pkg::BIT_EXT_PIN_FLAG] &
             interrupt_control[ifel_pkg::BIT_EXT_PIN_ENABLE]) |
            (interrupt_control[ifel_pkg::BIT_PORT_CHANGE_FLAG] &
             interrupt_control[ifel_pkg::BIT_PORT_CHANGE_ENABLE]) |
            (interrupt_control[ifel_pkg::BIT_PERIPH_ENABLE] &
             (|(periph_flags_a & periph_enables_a) |
              |(periph_flags_b & periph_enables_b)));
    end

    assign accept = global_irq_enable & pending & ~sleeping;
    assign wake   = sleeping & pending;
    // a source already pending turns the sleep instruction into a no-op
    assign enter_sleep = sleep_instr & ~sleeping & ~pending;

    // global enable, the hardware clear has priority over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
        end else if (accept || (wake && global_irq_enable)) begin
            global_irq_enable <= 1'b0;
        end else if (return_from_irq_instr) begin
            global_irq_enable <= 1'b1;
        end else if (wr_access &&
                     hit(paddr, ifel_pkg::OFS_INTERRUPT_CONTROL)) begin
            global_irq_enable <= wbyte[ifel_pkg::BIT_GLOBAL_IRQ_ENABLE];
        end
    end

    // enables of interrupt_control are plain read/write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_enables <= ifel_pkg::RST_INTERRUPT_CONTROL[6:3];
        end else if (wr_access &&
                     hit(paddr, ifel_pkg::OFS_INTERRUPT_CONTROL)) begin
            ctl_enables <= wbyte[6:3];
        end
    end

    // flags are sticky and set regardless of any enable
    always_comb begin
        next_ctl = sticky({5'h00, ctl_flags},
                          {5'h00, tmr_roll, ext_edge, port_change},
                          wr_access &&
                          hit(paddr, ifel_pkg::OFS_INTERRUPT_CONTROL),
                          wbyte);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_flags <= ifel_pkg::RST_INTERRUPT_CONTROL[2:0];
        end else begin
            ctl_flags <= next_ctl[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_flags_a <= ifel_pkg::RST_PERIPH;
            periph_flags_b <= ifel_pkg::RST_PERIPH;
        end else begin
            periph_flags_a <= sticky(periph_flags_a, periph_events_a,
                wr_access && hit(paddr, ifel_pkg::OFS_PERIPH_FLAGS_A),
                wbyte);
            periph_flags_b <= sticky(periph_flags_b, periph_events_b,
                wr_access && hit(paddr, ifel_pkg::OFS_PERIPH_FLAGS_B),
                wbyte);
        end
    end

    // peripheral enables and option
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_enables_a <= ifel_pkg::RST_PERIPH;
            periph_enables_b <= ifel_pkg::RST_PERIPH;
            option_reg       <= ifel_pkg::RST_OPTION;
        end else if (wr_access) begin
            if (hit(paddr, ifel_pkg::OFS_PERIPH_ENABLES_A)) begin
                periph_enables_a <= wbyte;
            end
            if (hit(paddr, ifel_pkg::OFS_PERIPH_ENABLES_B)) begin
                periph_enables_b <= wbyte;
            end
            if (hit(paddr, ifel_pkg::OFS_OPTION)) begin
                option_reg <= wbyte;
            end
        end
    end

    // sleep state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleeping <= 1'b0;
        end else if (wake) begin
            sleeping <= 1'b0;
        end else if (enter_sleep) begin
            sleeping <= 1'b1;
        end
    end

    // core redirection, vector on accept or on a wake with enable set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_push  <= 1'b0;
            pc_load     <= 1'b0;
            next_pc     <= '0;
            irq_request <= 1'b0;
        end else begin
            stack_push  <= accept | (wake & global_irq_enable);
            pc_load     <= accept | wake;
            irq_request <= global_irq_enable & pending;
            if (accept || (wake && global_irq_enable)) begin
                next_pc <= ifel_pkg::IRQ_VECTOR;
            end else if (wake) begin
                next_pc <= core_pc + ifel_pkg::PC_STEP;
            end
        end
    end

    // read mux, decoded in the setup cycle so data is ready in access
    always_comb begin
        next_rdata = 8'h00;
        next_err   = 1'b0;
        unique case (paddr)
            ifel_pkg::OFS_INTERRUPT_CONTROL: next_rdata = interrupt_control;
            ifel_pkg::OFS_OPTION:            next_rdata = option_reg;
            ifel_pkg::OFS_PERIPH_FLAGS_A:    next_rdata = periph_flags_a;
            ifel_pkg::OFS_PERIPH_FLAGS_B:    next_rdata = periph_flags_b;
            ifel_pkg::OFS_PERIPH_ENABLES_A:  next_rdata = periph_enables_a;
            ifel_pkg::OFS_PERIPH_ENABLES_B:  next_rdata = periph_enables_b;
            ifel_pkg::OFS_CORE_STATUS: begin
                next_rdata[ifel_pkg::BIT_STAT_SLEEPING] = sleeping;
                next_rdata[ifel_pkg::BIT_STAT_REQUEST]  = global_irq_enable & pending;
                next_rdata[ifel_pkg::BIT_STAT_PENDING]  = pending;
            end
            default: next_err = 1'b1;
        endcase
    end

    // one wait-free access cycle after every setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h00000000 :
                       {ifel_pkg::READ_PAD, next_rdata};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    AST_FLAG_SET_ANYWAY: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_edge |=> interrupt_control[ifel_pkg::BIT_EXT_PIN_FLAG])
        else $error("edge did not set external flag");

    AST_GIE_BLOCKS: assert property (
        @(posedge pclk) disable iff (!presetn)
        !global_irq_enable |=> !stack_push)
        else $error("vector taken with global enable clear");

    AST_VECTOR_NOW: assert property (
        @(posedge pclk) disable iff (!presetn)
        accept |=> pc_load && stack_push &&
                   next_pc == ifel_pkg::IRQ_VECTOR)
        else $error("accepted request not vectored next cycle");

    AST_ACCEPT_CLEARS_GIE: assert property (
        @(posedge pclk) disable iff (!presetn)
        stack_push |-> !global_irq_enable)
        else $error("global enable still set after acceptance");

    AST_RETURN_SETS_GIE: assert property (
        @(posedge pclk) disable iff (!presetn)
        return_from_irq_instr && !pending |=> global_irq_enable)
        else $error("return did not re-enable interrupts");

    AST_EXT_LATENCY: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_edge && global_irq_enable && !sleeping && !pending &&
        interrupt_control[ifel_pkg::BIT_EXT_PIN_ENABLE] &&
        !(psel && penable) ##1 !(psel && penable) |=> stack_push)
        else $error("external event latency exceeded");

    AST_TMR_ROLL: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(timer_zero_count) == ifel_pkg::TMR_TOP &&
        timer_zero_count == ifel_pkg::TMR_BOTTOM
        |=> interrupt_control[ifel_pkg::BIT_TIMER0_ROLLOVER_FLAG])
        else $error("rollover did not set timer flag");

    AST_WAKE_PC: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake && !global_irq_enable |=> pc_load && !stack_push && !sleeping &&
                         next_pc == $past(core_pc) + ifel_pkg::PC_STEP)
        else $error("wake with enable clear did not resume at pc+1");

    AST_WAKE_FLAG: assert property (
        @(posedge pclk) disable iff (!presetn)
        wake && !(psel && penable) |=>
        |{interrupt_control[2:0], periph_flags_a, periph_flags_b})
        else $error("wake left no flag set");

    AST_STICKY: assert property (
        @(posedge pclk) disable iff (!presetn)
        interrupt_control[ifel_pkg::BIT_EXT_PIN_FLAG] && !wr_access
        |=> interrupt_control[ifel_pkg::BIT_EXT_PIN_FLAG])
        else $error("external flag dropped without a write");
endmodule

// [test/ifel_core_model.sv]
// core sequencer model facing the interrupt logic's core side
`timescale 1ns/1ps
module ifel_core_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // commands from the bench
    input  wire logic        do_sleep,
    input  wire logic        do_ret,
    // interrupt logic side
    input  wire logic        stack_push,
    input  wire logic        pc_load,
    input  wire logic [12:0] next_pc,
    input  wire logic        sleeping,
    output logic             sleep_instr,
    output logic             return_from_irq_instr,
    output logic      [12:0] core_pc
);
    logic [12:0] stack_q[$];

    // pc stands still in power-down so the wake target is predictable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_pc               <= 13'h0000;
            sleep_instr           <= 1'b0;
            return_from_irq_instr <= 1'b0;
            stack_q.delete();
        end else begin
            sleep_instr           <= do_sleep;
            return_from_irq_instr <= do_ret;
            if (stack_push) begin
                stack_q.push_back(core_pc);
            end
            if (pc_load) begin
                core_pc <= next_pc;
            end else if (do_ret && stack_q.size() > 0) begin
                core_pc <= stack_q.pop_back();
            end else if (!sleeping) begin
                core_pc <= core_pc + 13'h0001;
            end
        end
    end
endmodule

// [test/ifel_top_test.sv]
// self-checking bench for the interrupt flag and enable logic
`timescale 1ns/1ps
module ifel_top_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic [3:0]  port_hi;
    logic [7:0]  tmr;
    logic [7:0]  ev_a;
    logic [7:0]  ev_b;
    logic        ret_i;
    logic        slp_i;
    logic [12:0] pc;
    logic        irq;
    logic        push;
    logic        load;
    logic [12:0] npc;
    logic        slp;
    logic        do_sleep;
    logic        do_ret;
    logic [31:0] rd_d;
    logic        rd_e;
    logic        q_ld;
    logic        slpm;
    logic [12:0] pc_s;
    int          fail_count;
    int          cmp_count;
    int          n;
    int          m[7];

    ifel_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_irq_pin(pin),
        .second_io_port_hi(port_hi), .timer_zero_count(tmr),
        .periph_events_a(ev_a), .periph_events_b(ev_b),
        .return_from_irq_instr(ret_i), .sleep_instr(slp_i),
        .core_pc(pc), .irq_request(irq), .stack_push(push),
        .pc_load(load), .next_pc(npc), .sleeping(slp));

    ifel_core_model i_core (.pclk(pclk), .presetn(presetn),
        .do_sleep(do_sleep), .do_ret(do_ret), .stack_push(push),
        .pc_load(load), .next_pc(npc), .sleeping(slp),
        .sleep_instr(slp_i), .return_from_irq_instr(ret_i),
        .core_pc(pc));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic timeout();
        chk("wait bound", 32'h0, 32'h1);
        stop_test();
    endtask

    // pending/status view worked out from the register model
    function automatic logic [31:0] stat();
        logic p;
        p = |(m[0][2:0] & m[0][5:3]);
        p = p | (m[0][6] & (|((m[2] & m[4]) | (m[3] & m[5]))));
        return {29'h0, p, p & m[0][7], slpm};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) timeout();
        rd_d = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a < 12'h018) m[a[4:2]] = int'(d[7:0]);
    endtask

    task automatic chk_rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        chk("read data", (a == 12'h018) ? stat() : m[a[4:2]], rd_d);
        chk("slave error", 32'h0, 32'(rd_e));
    endtask

    // counts edges up to a pc load, looked at once outputs settle
    task automatic wait_vec();
        for (n = 1; n <= 20; n++) begin
            @(posedge pclk);
            #1;
            if (load === 1'b1) break;
        end
        if (n > 20) timeout();
    endtask

    task automatic quiet();
        q_ld = 1'b0;
        repeat (10) begin
            @(posedge pclk);
            #1;
            if (load !== 1'b0) q_ld = 1'b1;
        end
    endtask

    task automatic cmd(input logic s);
        @(posedge pclk);
        do_sleep <= s;
        do_ret   <= ~s;
        @(posedge pclk);
        do_sleep <= 1'b0;
        do_ret   <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, pin, do_sleep, do_ret} = 7'h00;
        {paddr, pwdata, port_hi, tmr, ev_a, ev_b} = 72'h0;
        {fail_count, cmp_count, slpm} = 0;
        n = $urandom(21395);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        m = '{0, 255, 0, 0, 0, 0, 0};
        for (int i = 0; i < 7; i++) chk_rd(12'(i * 4));
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped error", 32'h1, 32'(rd_e));
        // flags rise with every enable clear
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            ev_a <= 8'h01 << i;
            ev_b <= 8'h80 >> i;
            @(posedge pclk);
            {ev_a, ev_b} <= 16'h0000;
            m[2] |= 1 << i;
            m[3] |= 128 >> i;
        end
        chk_rd(12'h008);
        chk_rd(12'h00c);
        @(posedge pclk);
        tmr <= 8'hff;
        @(posedge pclk);
        tmr     <= 8'h00;
        pin     <= 1'b1;
        port_hi <= 4'h5;
        repeat (6) @(posedge pclk);
        m[0] = 7;
        chk_rd(12'h000);
        wr(12'h000, 32'h0);
        chk_rd(12'h000);
        // falling edge selected: fall sets, rise does not
        wr(12'h004, 32'h0);
        @(posedge pclk);
        pin <= 1'b0;
        repeat (6) @(posedge pclk);
        m[0] = 2;
        chk_rd(12'h000);
        wr(12'h000, 32'h0);
        @(posedge pclk);
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_rd(12'h000);
        for (int i = 0; i < 8; i++) begin
            for (int j = 2; j < 6; j++) wr(12'(j * 4), 32'($urandom) & 255);
            for (int j = 2; j < 6; j++) chk_rd(12'(j * 4));
        end
        for (int j = 2; j < 6; j++) wr(12'(j * 4), 32'h0);
        // peripheral gate, then global gate
        wr(12'h010, 32'h01);
        wr(12'h000, 32'h80);
        @(posedge pclk);
        ev_a <= 8'h01;
        @(posedge pclk);
        ev_a <= 8'h00;
        m[2] = 1;
        quiet();
        chk("vector", 32'h0, 32'(q_ld));
        wr(12'h000, 32'hc0);
        wait_vec();
        chk("vector delay", 32'h1, 32'(n));
        chk("irq request", 32'h1, 32'(irq));
        chk("next pc", 32'(ifel_pkg::IRQ_VECTOR), 32'(npc));
        chk("stack push", 32'h1, 32'(push));
        m[0] = 32'h40;
        chk_rd(12'h000);
        chk_rd(12'h008);
        wr(12'h008, 32'h0);
        cmd(1'b0);
        m[0] = 32'hc0;
        chk_rd(12'h000);
        quiet();
        chk("vector", 32'h0, 32'(q_ld));
        wr(12'h000, 32'h20);
        @(posedge pclk);
        tmr <= 8'hff;
        @(posedge pclk);
        tmr <= 8'h00;
        quiet();
        chk("vector", 32'h0, 32'(q_ld));
        chk("irq request", 32'h0, 32'(irq));
        wr(12'h000, 32'ha4);
        wait_vec();
        chk("vector delay", 32'h1, 32'(n));
        wr(12'h000, 32'h90);
        @(posedge pclk);
        pin <= 1'b0;
        wait_vec();
        chk("latency ok", 32'h1, 32'(n >= 3 && n <= 4));
        m[0] = 32'h12;
        chk_rd(12'h000);
        // power-down, global enable clear, ext enable clear
        wr(12'h004, 32'h40);
        wr(12'h000, 32'h08);
        cmd(1'b1);
        chk("sleeping", 32'h1, 32'(slp));
        pc_s = pc;
        slpm = 1'b1;
        chk_rd(12'h018);
        @(posedge pclk);
        pin <= 1'b1;
        quiet();
        chk("vector", 32'h0, 32'(q_ld));
        @(posedge pclk);
        port_hi <= 4'ha;
        wait_vec();
        chk("next pc", 32'(pc_s + 13'h0001), 32'(npc));
        chk("stack push", 32'h0, 32'(push));
        chk("sleeping", 32'h0, 32'(slp));
        slpm = 1'b0;
        m[0] = 32'h0b;
        chk_rd(12'h000);
        // power-down with global enable set
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h88);
        cmd(1'b1);
        @(posedge pclk);
        port_hi <= 4'h3;
        wait_vec();
        chk("next pc", 32'(ifel_pkg::IRQ_VECTOR), 32'(npc));
        chk("stack push", 32'h1, 32'(push));
        m[0] = 32'h09;
        chk_rd(12'h000);
        // reset in mid-run drops the global enable
        wr(12'h000, 32'h80);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m = '{0, 255, 0, 0, 0, 0, 0};
        chk_rd(12'h000);
        stop_test();
    end
endmodule
